// ==== wirs_defines.svh ====
// register offsets, field positions, reset values and write masks of the per-port bank
// assumes a 5-bit register number inside one port's extended page
`ifndef WIRS_DEFINES_SVH
`define WIRS_DEFINES_SVH

`define WIRS_OFS_WAKE 5'h1b
`define WIRS_OFS_MASK 5'h1c
`define WIRS_OFS_STATUS 5'h1d
`define WIRS_OFS_ROLE 5'h1e
`define WIRS_ADDR_PORT 5

`define WIRS_WAKE_RST 16'h0f00
`define WIRS_MASK_RST 16'h0000
`define WIRS_ROLE_RST 16'h0000
`define WIRS_WAKE_WMASK 16'hcf03
`define WIRS_IRQ_WMASK 16'h301f
`define WIRS_ROLE_WMASK 16'hd000

`define WIRS_B_PW_EN 15
`define WIRS_B_PW_LEN 14
`define WIRS_B_REP_HI 11
`define WIRS_B_REP_LO 8
`define WIRS_B_ROUTE 1

`define WIRS_B_RXF 13
`define WIRS_B_TXF 12
`define WIRS_B_SWDONE 4
`define WIRS_B_LFAIL 3
`define WIRS_B_TQ 2
`define WIRS_B_TS 1
`define WIRS_B_WERR 0

`define WIRS_B_STARTUP 15
`define WIRS_B_ADV 14
`define WIRS_B_LPADV 13
`define WIRS_B_FORCE 12
`define WIRS_B_ROLE_HI 5
`define WIRS_B_ROLE_LO 4
`define WIRS_B_START 0

`endif

// ==== wirs_pkg.sv ====
// types shared by the wake, interrupt and timing-role register bank
// assumes nothing beyond a SystemVerilog tool
package wirs_pkg;

	// codes equal the role status field encoding
	typedef enum logic [1:0] {
		WIRS_SLAVE = 2'b00,
		WIRS_M2S = 2'b01,
		WIRS_S2M = 2'b10,
		WIRS_MASTER = 2'b11
	} wirs_role_e;

	typedef struct packed {
		logic rx_fifo;
		logic tx_fifo;
		logic eee_link_fail;
		logic rx_tq;
		logic wait_quiet;
		logic wake_err;
	} wirs_evt_s;

	typedef struct packed {
		logic [5:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} wirs_bus_s;

	typedef struct packed {
		logic pw_check_en;
		logic pw_len4;
		logic [4:0] rep_count;
	} wirs_wake_s;

	typedef struct packed {
		logic startup_en;
		logic advertise;
		logic force_en;
	} wirs_rs_cfg_s;

	typedef struct packed {
		logic [1:0][15:0] wake_and_irq_routing_ctrl;
		logic [1:0][15:0] extended_irq_mask;
		logic [1:0][15:0] timing_role_switch_ctrl;
		logic [15:0] rdata;
	} wirs_regs_s;

	typedef struct packed {
		logic [15:0] status;
	} wirs_irq_s;

	typedef struct packed {
		wirs_role_e role;
		logic link_q;
		logic start;
		logic done;
	} wirs_fsm_s;

endpackage

// ==== wirs_irq_status.sv ====
// one port's self-clearing extended interrupt status with its mask gate
// assumes event pulses and the read-clear pulse come from the same clock
`include "wirs_defines.svh"
module wirs_irq_status
	import wirs_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic soft_rst_i,
	input wire logic [15:0] set_i,
	input wire logic clr_i,
	input wire logic [15:0] mask_i,
	output logic [15:0] status_o,
	output logic irq_o
);

	wirs_irq_s st;
	wirs_irq_s next_st;

	always_comb
	begin
		next_st = st;
		// set wins over a read in the same cycle so no event is lost
		if (clr_i || soft_rst_i)
		begin
			next_st.status = set_i & `WIRS_IRQ_WMASK;
		end
		else
		begin
			next_st.status = (st.status | set_i) & `WIRS_IRQ_WMASK;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign status_o = st.status;
	assign irq_o = |(st.status & mask_i);

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	chk_set_wins_clear: assert property (clr_i && set_i[`WIRS_B_RXF] |=> status_o[`WIRS_B_RXF])
		else $error("event lost against a status read");
	chk_read_clears: assert property (clr_i && set_i == 16'h0000 |=> status_o == 16'h0000)
		else $error("status not cleared after read");
	chk_masked_quiet: assert property (mask_i == 16'h0000 |-> !irq_o)
		else $error("interrupt raised with all masks off");

endmodule

// ==== wirs_role_fsm.sv ====
// one port's timing-role tracker and hitless switchover sequencer
// assumes the gigabit dsp reports the end of a switchover with a one-cycle pulse
module wirs_role_fsm
	import wirs_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic soft_rst_i,
	input wire logic link_up_i,
	input wire logic neg_master_i,
	input wire logic start_i,
	input wire logic dsp_done_i,
	output wirs_role_e role_o,
	output logic switch_start_o,
	output logic done_o
);

	wirs_fsm_s st;
	wirs_fsm_s next_st;

	always_comb
	begin
		next_st = st;
		next_st.link_q = link_up_i;
		next_st.start = 1'b0;
		next_st.done = 1'b0;
		if (soft_rst_i)
		begin
			next_st = '0;
		end
		else if (link_up_i && !st.link_q)
		begin
			next_st.role = neg_master_i ? WIRS_MASTER : WIRS_SLAVE;
		end
		else
		begin
			unique case (st.role)
				WIRS_SLAVE, WIRS_MASTER:
				begin
					// a start with the link down is dropped here
					if (start_i && link_up_i)
					begin
						next_st.role = (st.role == WIRS_SLAVE) ? WIRS_S2M : WIRS_M2S;
						next_st.start = 1'b1;
					end
				end
				WIRS_S2M, WIRS_M2S:
				begin
					if (dsp_done_i)
					begin
						next_st.role = (st.role == WIRS_S2M) ? WIRS_MASTER : WIRS_SLAVE;
						next_st.done = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign role_o = st.role;
	assign switch_start_o = st.start;
	assign done_o = st.done;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_start_taken;
		!soft_rst_i && st.link_q && link_up_i && start_i &&
			(role_o == WIRS_SLAVE || role_o == WIRS_MASTER);
	endsequence

	sequence s_switch_end;
		!soft_rst_i && st.link_q && dsp_done_i && (role_o == WIRS_S2M || role_o == WIRS_M2S);
	endsequence

	chk_start_begins: assert property (s_start_taken |=> switch_start_o &&
		(role_o == WIRS_S2M || role_o == WIRS_M2S))
		else $error("switchover not begun after start");
	chk_switch_done: assert property (s_switch_end |=> done_o &&
		(role_o == WIRS_MASTER || role_o == WIRS_SLAVE))
		else $error("switchover end not reported");
	chk_linkup_role: assert property (!soft_rst_i && link_up_i && !st.link_q |=>
		role_o == ($past(neg_master_i) ? WIRS_MASTER : WIRS_SLAVE))
		else $error("role not taken from negotiation at link-up");

endmodule

// ==== wirs_regs.sv ====
// dual-port bank of wake, interrupt routing, interrupt mask/status and timing-role registers
// assumes every input comes from logic on sys_clk_i, so none is synchronised here
`include "wirs_defines.svh"
module wirs_regs
	import wirs_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire wirs_bus_s bus_i,
	output logic [15:0] rdata_o,
	input wire wirs_evt_s [1:0] evt_i,
	input wire logic [1:0] soft_reset_i,
	input wire logic [1:0] link_up_i,
	input wire logic [1:0] neg_master_i,
	input wire logic [1:0] lp_adv_i,
	input wire logic [1:0] dsp_done_i,
	output wirs_wake_s [1:0] wake_o,
	output wirs_rs_cfg_s [1:0] rs_cfg_o,
	output logic [1:0] switch_start_o,
	output logic port0_interrupt_pin_o,
	output logic port1_interrupt_pin_o
);

	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_WAKE = 3'h1;
	localparam logic [2:0] SEL_MASK = 3'h2;
	localparam logic [2:0] SEL_STATUS = 3'h3;
	localparam logic [2:0] SEL_ROLE = 3'h4;

	wirs_regs_s st;
	wirs_regs_s next_st;
	logic [1:0][15:0] set_vec;
	logic [1:0][15:0] status;
	logic [1:0] clr_rd;
	logic [1:0] irq;
	logic [1:0] sw_done;
	wirs_role_e [1:0] role;
	logic [2:0] rd_sel;
	logic [2:0] wr_sel;
	logic rd_port;
	logic wr_port;

	// register number to bank slot; used for both the write and read paths
	function automatic logic [2:0] reg_slot(input logic [4:0] num);
		logic [2:0] s;
		s = SEL_NONE;
		unique case (num)
			`WIRS_OFS_WAKE: s = SEL_WAKE;
			`WIRS_OFS_MASK: s = SEL_MASK;
			`WIRS_OFS_STATUS: s = SEL_STATUS;
			`WIRS_OFS_ROLE: s = SEL_ROLE;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction

	assign rd_sel = reg_slot(bus_i.addr[4:0]);
	assign wr_sel = reg_slot(bus_i.addr[4:0]);
	assign rd_port = bus_i.addr[`WIRS_ADDR_PORT];
	assign wr_port = bus_i.addr[`WIRS_ADDR_PORT];

	// role register as read: partner advertisement and role field are live state
	function automatic logic [15:0] role_word(input logic [15:0] ctrl, input logic lp,
		input wirs_role_e r);
		logic [15:0] w;
		w = ctrl & `WIRS_ROLE_WMASK;
		w[`WIRS_B_LPADV] = lp;
		w[`WIRS_B_ROLE_HI:`WIRS_B_ROLE_LO] = r;
		w[`WIRS_B_START] = ctrl[`WIRS_B_START];
		return w;
	endfunction

	always_comb
	begin
		next_st = st;
		next_st.rdata = 16'h0000;
		for (int p = 0; p < 2; p++)
		begin
			// start bit lives one cycle; the sequencer ignores it mid-switchover
			next_st.timing_role_switch_ctrl[p][`WIRS_B_START] = 1'b0;
			if (bus_i.wr && wr_port == p[0])
			begin
				unique case (wr_sel)
					SEL_WAKE:
						next_st.wake_and_irq_routing_ctrl[p] = bus_i.wdata & `WIRS_WAKE_WMASK;
					SEL_MASK:
						next_st.extended_irq_mask[p] = bus_i.wdata & `WIRS_IRQ_WMASK;
					SEL_ROLE:
					begin
						next_st.timing_role_switch_ctrl[p] = bus_i.wdata &
							(`WIRS_ROLE_WMASK | 16'h0001);
					end
					default:
					begin
						// status is read-only and unmapped slots drop the write
					end
				endcase
			end
			// soft reset leaves every sticky field alone; only the start bit is volatile
			if (soft_reset_i[p])
				next_st.timing_role_switch_ctrl[p][`WIRS_B_START] = 1'b0;
		end
		if (bus_i.rd)
		begin
			unique case (rd_sel)
				SEL_WAKE:
					next_st.rdata = st.wake_and_irq_routing_ctrl[rd_port];
				SEL_MASK:
					next_st.rdata = st.extended_irq_mask[rd_port];
				SEL_STATUS:
					next_st.rdata = status[rd_port];
				SEL_ROLE:
				begin
					next_st.rdata = role_word(st.timing_role_switch_ctrl[rd_port],
						lp_adv_i[rd_port], role[rd_port]);
				end
				default:
					next_st.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st.wake_and_irq_routing_ctrl <= {2{`WIRS_WAKE_RST}};
			st.extended_irq_mask <= {2{`WIRS_MASK_RST}};
			st.timing_role_switch_ctrl <= {2{`WIRS_ROLE_RST}};
			st.rdata <= 16'h0000;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign rdata_o = st.rdata;

	for (genvar p = 0; p < 2; p++)
	begin : g_port
		always_comb
		begin
			set_vec[p] = 16'h0000;
			set_vec[p][`WIRS_B_RXF] = evt_i[p].rx_fifo;
			set_vec[p][`WIRS_B_TXF] = evt_i[p].tx_fifo;
			set_vec[p][`WIRS_B_SWDONE] = sw_done[p];
			set_vec[p][`WIRS_B_LFAIL] = evt_i[p].eee_link_fail;
			set_vec[p][`WIRS_B_TQ] = evt_i[p].rx_tq;
			set_vec[p][`WIRS_B_TS] = evt_i[p].wait_quiet;
			set_vec[p][`WIRS_B_WERR] = evt_i[p].wake_err;
		end

		// the read that returns the status also clears it on the same edge
		assign clr_rd[p] = bus_i.rd && rd_sel == SEL_STATUS && rd_port == p;

		wirs_irq_status u_irq (
			.sys_clk_i(sys_clk_i),
			.arst_n_i(arst_n_i),
			.soft_rst_i(soft_reset_i[p]),
			.set_i(set_vec[p]),
			.clr_i(clr_rd[p]),
			.mask_i(st.extended_irq_mask[p]),
			.status_o(status[p]),
			.irq_o(irq[p])
		);

		wirs_role_fsm u_role (
			.sys_clk_i(sys_clk_i),
			.arst_n_i(arst_n_i),
			.soft_rst_i(soft_reset_i[p]),
			.link_up_i(link_up_i[p]),
			.neg_master_i(neg_master_i[p]),
			.start_i(st.timing_role_switch_ctrl[p][`WIRS_B_START]),
			.dsp_done_i(dsp_done_i[p]),
			.role_o(role[p]),
			.switch_start_o(switch_start_o[p]),
			.done_o(sw_done[p])
		);

		assign wake_o[p].pw_check_en = st.wake_and_irq_routing_ctrl[p][`WIRS_B_PW_EN];
		assign wake_o[p].pw_len4 = st.wake_and_irq_routing_ctrl[p][`WIRS_B_PW_LEN];
		assign wake_o[p].rep_count = {1'b0,
			st.wake_and_irq_routing_ctrl[p][`WIRS_B_REP_HI:`WIRS_B_REP_LO]} + 5'h01;
		assign rs_cfg_o[p].startup_en = st.timing_role_switch_ctrl[p][`WIRS_B_STARTUP];
		assign rs_cfg_o[p].advertise = st.timing_role_switch_ctrl[p][`WIRS_B_ADV];
		assign rs_cfg_o[p].force_en = st.timing_role_switch_ctrl[p][`WIRS_B_FORCE];
	end

	// the routing bit is a device-wide choice, held in port 0's copy
	logic route_split;
	assign route_split = st.wake_and_irq_routing_ctrl[0][`WIRS_B_ROUTE];
	assign port0_interrupt_pin_o = route_split ? irq[0] : |irq;
	assign port1_interrupt_pin_o = route_split ? irq[1] : |irq;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	chk_route_merged: assert property (!route_split |->
		port0_interrupt_pin_o == port1_interrupt_pin_o &&
		port0_interrupt_pin_o == ((status[0] & st.extended_irq_mask[0]) != 16'h0000 ||
		(status[1] & st.extended_irq_mask[1]) != 16'h0000))
		else $error("merged interrupt pins disagree");
	chk_route_split: assert property (route_split |->
		port1_interrupt_pin_o == ((status[1] & st.extended_irq_mask[1]) != 16'h0000))
		else $error("port 1 pin not driven by port 1 alone");
	chk_start_selfclr: assert property (bus_i.wr && bus_i.addr == {1'b0, `WIRS_OFS_ROLE} &&
		bus_i.wdata[0] && !soft_reset_i[0] |=> st.timing_role_switch_ctrl[0][0] ##1
		!st.timing_role_switch_ctrl[0][0])
		else $error("start bit not self-cleared");
	chk_sticky_keep: assert property (soft_reset_i[0] && !bus_i.wr |=>
		st.extended_irq_mask[0] == $past(st.extended_irq_mask[0]) &&
		st.wake_and_irq_routing_ctrl[0] == $past(st.wake_and_irq_routing_ctrl[0]))
		else $error("sticky register lost on soft reset");
	chk_rx_fifo_set: assert property (evt_i[1].rx_fifo |=>
		status[1][`WIRS_B_RXF])
		else $error("rx fifo event did not set status");
	chk_read_return: assert property (bus_i.rd && bus_i.addr == {1'b0, `WIRS_OFS_MASK} |=>
		rdata_o == $past(st.extended_irq_mask[0]))
		else $error("mask read returned wrong data");

	// bus steps that the register checks below start from
	sequence s_wr_wake0;
		bus_i.wr && bus_i.addr == {1'b0, `WIRS_OFS_WAKE};
	endsequence

	sequence s_wr_wake1;
		bus_i.wr && bus_i.addr == {1'b1, `WIRS_OFS_WAKE};
	endsequence

	sequence s_rd_status0;
		bus_i.rd && bus_i.addr == {1'b0, `WIRS_OFS_STATUS};
	endsequence

	sequence s_rd_role0;
		bus_i.rd && bus_i.addr == {1'b0, `WIRS_OFS_ROLE};
	endsequence

	chk_pw_check_en: assert property (s_wr_wake0 |=>
		wake_o[0].pw_check_en == $past(bus_i.wdata[15]))
		else $error("password check enable not taken from write");
	chk_pw_length: assert property (s_wr_wake0 |=>
		wake_o[0].pw_len4 == $past(bus_i.wdata[14]))
		else $error("password length not taken from write");
	chk_rep_count0: assert property (s_wr_wake0 |=>
		wake_o[0].rep_count == {1'b0, $past(bus_i.wdata[11:8])} + 5'h01)
		else $error("port 0 repetition count wrong");
	chk_rep_count1: assert property (s_wr_wake1 |=>
		wake_o[1].rep_count == {1'b0, $past(bus_i.wdata[11:8])} + 5'h01)
		else $error("port 1 repetition count wrong");
	chk_rep_range0: assert property (wake_o[0].rep_count != 5'h00)
		else $error("port 0 repetition count zero");
	chk_rep_range1: assert property (wake_o[1].rep_count != 5'h00)
		else $error("port 1 repetition count zero");
	chk_route_p0_split: assert property (route_split |->
		port0_interrupt_pin_o == ((status[0] & st.extended_irq_mask[0]) != 16'h0000))
		else $error("port 0 pin not driven by port 0 alone");
	chk_all_masked: assert property (st.extended_irq_mask[0] == 16'h0000 &&
		st.extended_irq_mask[1] == 16'h0000 |-> !port0_interrupt_pin_o && !port1_interrupt_pin_o)
		else $error("interrupt pin high with every mask off");
	chk_mask_stored: assert property (bus_i.wr && bus_i.addr == {1'b0, `WIRS_OFS_MASK} |=>
		st.extended_irq_mask[0] == ($past(bus_i.wdata) & `WIRS_IRQ_WMASK))
		else $error("mask write not stored");
	chk_mask_rsvd0: assert property ((st.extended_irq_mask[0] & ~`WIRS_IRQ_WMASK) == 16'h0000)
		else $error("port 0 reserved mask bit set");
	chk_mask_rsvd1: assert property ((st.extended_irq_mask[1] & ~`WIRS_IRQ_WMASK) == 16'h0000)
		else $error("port 1 reserved mask bit set");
	chk_status_rsvd: assert property ((status[0] & ~`WIRS_IRQ_WMASK) == 16'h0000)
		else $error("reserved status bit set");
	chk_status_read: assert property (s_rd_status0 |=> rdata_o == $past(status[0]))
		else $error("status read returned wrong data");
	chk_status_clear: assert property (s_rd_status0 ##0 set_vec[0] == 16'h0000 |=>
		status[0] == 16'h0000)
		else $error("status not cleared by its read");
	chk_rdata_idle: assert property (!bus_i.rd |=> rdata_o == 16'h0000)
		else $error("read data not zero outside a read");
	chk_rx_fifo_p0: assert property (evt_i[0].rx_fifo |=> status[0][`WIRS_B_RXF])
		else $error("port 0 rx fifo event lost");
	chk_tx_fifo_set: assert property (evt_i[0].tx_fifo |=> status[0][`WIRS_B_TXF])
		else $error("tx fifo event lost");
	chk_link_fail_set: assert property (evt_i[0].eee_link_fail |=> status[0][`WIRS_B_LFAIL])
		else $error("link fail event lost");
	chk_tq_set: assert property (evt_i[0].rx_tq |=> status[0][`WIRS_B_TQ])
		else $error("tq timer event lost");
	chk_ts_set: assert property (evt_i[0].wait_quiet |=> status[0][`WIRS_B_TS])
		else $error("wait quiet event lost");
	chk_wake_err_set: assert property (evt_i[0].wake_err |=> status[0][`WIRS_B_WERR])
		else $error("wake error event lost");
	chk_done_status: assert property (sw_done[0] |=> status[0][`WIRS_B_SWDONE])
		else $error("switchover end did not set status");
	chk_lp_adv: assert property (s_rd_role0 |=> rdata_o[`WIRS_B_LPADV] == $past(lp_adv_i[0]))
		else $error("partner advertisement not shown");
	chk_role_field: assert property (s_rd_role0 |=> rdata_o[5:4] == $past(role[0]))
		else $error("role field not shown");
	chk_role_rsvd: assert property (s_rd_role0 |=>
		rdata_o[11:6] == 6'h00 && rdata_o[3:1] == 3'h0)
		else $error("reserved role bits not zero");
	chk_start_pulse: assert property (switch_start_o[0] |->
		role[0] == WIRS_S2M || role[0] == WIRS_M2S)
		else $error("switchover begun without transitional role");
	chk_irq_pend0: assert property ((status[0] & st.extended_irq_mask[0]) != 16'h0000 |->
		port0_interrupt_pin_o)
		else $error("port 0 pending interrupt not on its pin");
	chk_irq_pend1: assert property ((status[1] & st.extended_irq_mask[1]) != 16'h0000 |->
		port1_interrupt_pin_o)
		else $error("port 1 pending interrupt not on its pin");
	chk_soft_status: assert property (soft_reset_i[0] && set_vec[0] == 16'h0000 |=>
		status[0] == 16'h0000)
		else $error("soft reset left status pending");
	chk_soft_role_ctrl: assert property (soft_reset_i[0] && !bus_i.wr |=>
		st.timing_role_switch_ctrl[0][15:12] == $past(st.timing_role_switch_ctrl[0][15:12]))
		else $error("role control lost on soft reset");

endmodule

// ==== wirs_dsp_model.sv ====
// gigabit dsp stand-in that finishes each started role switchover after a set delay
// assumes switch_start_i is a one-cycle pulse on sys_clk_i
module wirs_dsp_model
	import wirs_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic switch_start_i,
	input wire logic [7:0] delay_i,
	output logic dsp_done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] cnt;
	// a zero delay still answers two cycles after the start cycle, never in the start cycle itself
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt <= 9'h0;
			dsp_done_o <= 1'b0;
		end
		else
		begin
			dsp_done_o <= 1'b0;
			if (switch_start_i)
				cnt <= {1'b0, delay_i} + 9'h1;
			else if (cnt != 9'h0)
			begin
				cnt <= cnt - 9'h1;
				dsp_done_o <= (cnt == 9'h1);
			end
		end
	end
endmodule

// ==== test_wirs_regs.sv ====
// self-checking bench for the dual-port wake, interrupt and timing-role bank
// assumes the dsp stand-in model is compiled beside the design
`include "wirs_defines.svh"
module test_wirs_regs
	import wirs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	wirs_bus_s bus = '0;
	wirs_evt_s [1:0] evt = '0;
	logic [1:0] soft_rst = 2'h0;
	logic [1:0] link = 2'h0;
	logic [1:0] negm = 2'h0;
	logic [1:0] lpadv = 2'h0;
	wire [1:0] done;
	logic [15:0] rdata;
	wirs_wake_s [1:0] wake;
	wirs_rs_cfg_s [1:0] rs;
	logic [1:0] sw_start;
	logic pin0;
	logic pin1;
	wire [15:0] pins = {14'h0, pin1, pin0};
	logic [7:0] dly = 8'h0;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	int n;
	int sb [6] = '{0, 1, 2, 3, 12, 13};
	logic [7:0] dl [3] = '{8'h6, 8'h6, 8'h0};
	logic [15:0] mid [3] = '{16'h0020, 16'h0010, 16'h0000};
	logic [15:0] fin [3] = '{16'h0030, 16'h0000, 16'h0030};

	wirs_regs dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .bus_i(bus), .rdata_o(rdata),
		.evt_i(evt), .soft_reset_i(soft_rst), .link_up_i(link), .neg_master_i(negm),
		.lp_adv_i(lpadv), .dsp_done_i(done), .wake_o(wake), .rs_cfg_o(rs),
		.switch_start_o(sw_start), .port0_interrupt_pin_o(pin0), .port1_interrupt_pin_o(pin1));

	for (genvar p = 0; p < 2; p++)
	begin : g_dsp
		wirs_dsp_model m (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
			.switch_start_i(sw_start[p]), .delay_i(dly), .dsp_done_o(done[p]));
	end

	always #10 sys_clk_i = ~sys_clk_i;

	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// the run needs well under a thousand cycles
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic p, input logic [4:0] a, input logic [15:0] v);
		@(posedge sys_clk_i);
		bus <= '{addr: {p, a}, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk_i);
		bus.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rchk(input string nm, input logic p, input logic [4:0] a, input logic [15:0] e);
		@(posedge sys_clk_i);
		bus <= '{addr: {p, a}, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk_i);
		bus.rd <= 1'b0;
		#1;
		chk(nm, e, rdata);
	endtask

	task automatic pulse(input logic p, input int i);
		@(posedge sys_clk_i);
		evt[p] <= wirs_evt_s'(6'h1 << i);
		@(posedge sys_clk_i);
		evt[p] <= '0;
		#1;
	endtask

	initial
	begin
		repeat (10) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			rchk("wake_rst", p[0], `WIRS_OFS_WAKE, 16'h0f00);
			rchk("mask_rst", p[0], `WIRS_OFS_MASK, 16'h0000);
			rchk("status_rst", p[0], `WIRS_OFS_STATUS, 16'h0000);
			rchk("role_rst", p[0], `WIRS_OFS_ROLE, 16'h0000);
		end
		chk("wake_cfg_rst", 16'h0010, 16'(wake[0]));
		$display("test reset_values done");

		wr(1'b0, `WIRS_OFS_WAKE, 16'hffff);
		rchk("wake_rw", 1'b0, `WIRS_OFS_WAKE, 16'hcf03);
		wr(1'b1, `WIRS_OFS_MASK, 16'hffff);
		rchk("mask_rw", 1'b1, `WIRS_OFS_MASK, 16'h301f);
		wr(1'b1, `WIRS_OFS_MASK, 16'h0000);
		wr(1'b0, `WIRS_OFS_STATUS, 16'hffff);
		rchk("status_ro", 1'b0, `WIRS_OFS_STATUS, 16'h0000);
		wr(1'b0, 5'h05, 16'hffff);
		rchk("unmapped", 1'b0, 5'h05, 16'h0000);
		for (int r = 0; r < 16; r++)
		begin
			wr(1'b1, `WIRS_OFS_WAKE, {2'(r), 2'h0, 4'(r), 8'h00});
			#1;
			chk("wake_cfg", 16'({2'(r), 5'(r + 1)}), 16'(wake[1]));
		end
		$display("test wake_fields done");

		wr(1'b0, `WIRS_OFS_WAKE, 16'h0000);
		for (int i = 0; i < 6; i++)
		begin
			pulse(1'b0, i);
			chk("pin_masked", 16'h0, pins);
			rchk("status_set", 1'b0, `WIRS_OFS_STATUS, 16'h1 << sb[i]);
			rchk("status_clr", 1'b0, `WIRS_OFS_STATUS, 16'h0);
			wr(1'b0, `WIRS_OFS_MASK, 16'h1 << sb[i]);
			pulse(1'b0, i);
			chk("pin_unmasked", 16'h3, pins);
			rchk("status_evt", 1'b0, `WIRS_OFS_STATUS, 16'h1 << sb[i]);
			chk("pin_cleared", 16'h0, pins);
			wr(1'b0, `WIRS_OFS_MASK, 16'h0);
		end
		$display("test events done");

		wr(1'b1, `WIRS_OFS_MASK, 16'h2000);
		pulse(1'b1, 5);
		chk("route_or", 16'h3, pins);
		wr(1'b0, `WIRS_OFS_WAKE, 16'h0002);
		#1;
		chk("route_split", 16'h2, pins);
		rchk("status_p1", 1'b1, `WIRS_OFS_STATUS, 16'h2000);
		chk("route_idle", 16'h0, pins);
		$display("test routing done");

		@(posedge sys_clk_i);
		link <= 2'h3;
		negm <= 2'h2;
		lpadv <= 2'h1;
		rchk("role_slave", 1'b0, `WIRS_OFS_ROLE, 16'h2000);
		rchk("role_master", 1'b1, `WIRS_OFS_ROLE, 16'h0030);
		wr(1'b0, `WIRS_OFS_MASK, 16'h0010);
		for (int k = 0; k < 3; k++)
		begin
			dly <= dl[k];
			wr(1'b0, `WIRS_OFS_ROLE, 16'hd001);
			n = 0;
			while (sw_start[0] !== 1'b1 && n < 9)
			begin
				@(posedge sys_clk_i);
				#1 n++;
			end
			chk("sw_start", 16'h1, 16'(sw_start[0]));
			if (dl[k] != 8'h0)
				rchk("role_mid", 1'b0, `WIRS_OFS_ROLE, 16'hf000 | mid[k]);
			n = 0;
			while (pin0 !== 1'b1 && n < 20)
			begin
				@(posedge sys_clk_i);
				#1 n++;
			end
			chk("sw_irq", 16'h1, 16'(pin0));
			rchk("role_end", 1'b0, `WIRS_OFS_ROLE, 16'hf000 | fin[k]);
			rchk("sw_done", 1'b0, `WIRS_OFS_STATUS, 16'h0010);
		end
		$display("test switchover done");

		pulse(1'b0, 0);
		@(posedge sys_clk_i);
		soft_rst <= 2'h1;
		@(posedge sys_clk_i);
		soft_rst <= 2'h0;
		rchk("sticky_wake", 1'b0, `WIRS_OFS_WAKE, 16'h0002);
		rchk("sticky_mask", 1'b0, `WIRS_OFS_MASK, 16'h0010);
		rchk("soft_status", 1'b0, `WIRS_OFS_STATUS, 16'h0000);
		chk("sticky_cfg", 16'h7, 16'(rs[0]));
		$display("test soft_reset done");
		end_sim();
	end
endmodule
